// ===== include/arbiter_consts.svh
// Purpose: timing-free constants for the shared bus priority arbiter
// Assumes: included by bare name from the design files
// Notes:   priority numbers are three bits wide; a lower number is a stronger claim
`ifndef ARBITER_CONSTS_SVH
`define ARBITER_CONSTS_SVH

// ****************************************************************
// widths and number of request lines
// ****************************************************************
`define ARB_PRIO_W          3
`define ARB_LINE_W          3
`define ARB_NUM_LINES       6

// ****************************************************************
// request line positions
// ****************************************************************
`define ARB_LINE_MEM_LOWER_A 3'h0
`define ARB_LINE_MEM_LOWER_B 3'h1
`define ARB_LINE_MEM_UPPER_A 3'h2
`define ARB_LINE_MEM_UPPER_B 3'h3
`define ARB_LINE_SELCH       3'h4
`define ARB_LINE_PROC        3'h5

// ****************************************************************
// usual jumper settings and the step to a memory card's second number
// ****************************************************************
`define ARB_PRIO_MEM_LOWER  3'h0
`define ARB_PRIO_MEM_UPPER  3'h2
`define ARB_PRIO_SELCH      3'h4
`define ARB_PRIO_PROC       3'h5
`define ARB_PRIO_STEP       3'h1

`endif

// ===== include/arbiter_pkg.sv
// Purpose: types used by the arbiter; its processor-side access logic uses none of them
// Assumes: arbiter_consts.svh gives the widths
// Notes:   no constants live here, only types
`include "arbiter_consts.svh"

package arbiter_pkg;

    typedef logic [`ARB_PRIO_W-1:0] prio_t;
    typedef logic [`ARB_LINE_W-1:0] line_t;

    typedef enum logic {
        ARB_IDLE,
        ARB_OWNED
    } arb_state_t;

endpackage

// ===== src/processor_local_access.sv
// Purpose: local access logic of the processor module in front of the shared bus
// Assumes: bus_gnt comes from a flip-flop in the arbiter
// Notes:   the io processor always beats the cpu; the choice freezes while granted
`timescale 1ns/100ps

module processor_local_access (
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic io_processor_req,
    input  wire logic cpu_req,
    input  wire logic bus_gnt,
    output logic      proc_req,
    output logic      io_processor_gnt,
    output logic      cpu_gnt
);

    // ****************************************************************
    // local contention
    // ****************************************************************
    logic pick_iop_q;
    logic pick_iop_d;

    // the pick follows the requests until the bus is ours, then holds,
    // so ownership cannot slide from cpu to io processor mid-transfer
    assign pick_iop_d = bus_gnt ? pick_iop_q : io_processor_req;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pick_iop_q <= 1'b0;
        end else begin
            pick_iop_q <= pick_iop_d;
        end
    end

    // ****************************************************************
    // request toward the arbiter and local grants
    // ****************************************************************
    wire owner_req = pick_iop_q ? io_processor_req : cpu_req;

    // while granted only the local owner's request keeps the bus held
    assign proc_req         = bus_gnt ? owner_req : (io_processor_req | cpu_req);
    assign io_processor_gnt = bus_gnt & pick_iop_q;
    assign cpu_gnt          = bus_gnt & ~pick_iop_q;

endmodule

// ===== src/shared_bus_priority_arbiter.sv
// Purpose: fixed-priority arbiter for the shared system transfer bus
// Assumes: all inputs synchronous to mclk; jumpers stable while rst_n is low
// Notes:   one cycle from request to grant; handover is seamless except between io processor and cpu, which takes one extra cycle
`timescale 1ns/100ps
`include "arbiter_consts.svh"

// How it works
// - only one request line ever holds the bus; grants come from one owner index.
// - among simultaneous requesters the strongest claim wins the free bus.
// - a loser waits until the owner drops its request; the owner drops when done.
// - every priority number comes from jumper inputs caught during reset, never software.
// - the smaller priority number beats the larger one.
// - processor module jumpers usually set number 5, the weakest claim.
// - lower memory card answers its jumper number and the next, usually 0 and 1.
// - upper memory card answers its jumper number and the next, usually 2 and 3.
// - banks 0-7 and 8-15 each have their own memory control card request pair.
// - selector channel requests count only when installed, usually at number 4.
// - inside the processor module the io processor always beats the cpu.
module shared_bus_priority_arbiter (
    input  wire logic                   mclk,
    input  wire logic                   rst_n,
    input  wire logic [`ARB_PRIO_W-1:0] mem_lower_jumper,
    input  wire logic [`ARB_PRIO_W-1:0] mem_upper_jumper,
    input  wire logic [`ARB_PRIO_W-1:0] selch_jumper,
    input  wire logic [`ARB_PRIO_W-1:0] proc_jumper,
    input  wire logic                   selch_installed,
    input  wire logic [1:0]             mem_lower_req,
    input  wire logic [1:0]             mem_upper_req,
    input  wire logic                   selch_req,
    input  wire logic                   io_processor_req,
    input  wire logic                   cpu_req,
    output logic      [1:0]             mem_lower_gnt,
    output logic      [1:0]             mem_upper_gnt,
    output logic                        selch_gnt,
    output logic                        io_processor_gnt,
    output logic                        cpu_gnt,
    output logic                        bus_busy,
    output logic      [`ARB_PRIO_W-1:0] bus_owner_num
);

    localparam int NL = `ARB_NUM_LINES;

    // ****************************************************************
    // jumper capture
    // ****************************************************************
    arbiter_pkg::prio_t mem_lower_prio_q;
    arbiter_pkg::prio_t mem_upper_prio_q;
    arbiter_pkg::prio_t selch_prio_q;
    arbiter_pkg::prio_t proc_prio_q;
    logic               selch_present_q;

    // jumpers are straps: they follow the pins while reset is held and
    // freeze at release, so a bumped jumper cannot reorder a live bus
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            mem_lower_prio_q <= mem_lower_jumper;
            mem_upper_prio_q <= mem_upper_jumper;
            selch_prio_q     <= selch_jumper;
            proc_prio_q      <= proc_jumper;
            selch_present_q  <= selch_installed;
        end
    end

    // ****************************************************************
    // request lines and their priority numbers
    // ****************************************************************
    logic                     proc_req;
    logic [NL-1:0]            line_req;
    arbiter_pkg::prio_t       line_num [NL];

    // each memory control card claims its jumper number and the one after
    assign line_num[`ARB_LINE_MEM_LOWER_A] = mem_lower_prio_q;
    assign line_num[`ARB_LINE_MEM_LOWER_B] = mem_lower_prio_q + `ARB_PRIO_STEP;
    assign line_num[`ARB_LINE_MEM_UPPER_A] = mem_upper_prio_q;
    assign line_num[`ARB_LINE_MEM_UPPER_B] = mem_upper_prio_q + `ARB_PRIO_STEP;
    assign line_num[`ARB_LINE_SELCH]       = selch_prio_q;
    assign line_num[`ARB_LINE_PROC]        = proc_prio_q;

    // two separate cards, so the lower and upper banks request independently
    assign line_req[`ARB_LINE_MEM_LOWER_A] = mem_lower_req[0];
    assign line_req[`ARB_LINE_MEM_LOWER_B] = mem_lower_req[1];
    assign line_req[`ARB_LINE_MEM_UPPER_A] = mem_upper_req[0];
    assign line_req[`ARB_LINE_MEM_UPPER_B] = mem_upper_req[1];
    // an absent channel must not win on a floating request pin
    assign line_req[`ARB_LINE_SELCH]       = selch_req & selch_present_q;
    assign line_req[`ARB_LINE_PROC]        = proc_req;

    // ****************************************************************
    // priority comparison
    // ****************************************************************
    // tie on equal numbers (jumper mistake) goes to the lower line index,
    // which keeps a single winner instead of a double grant
    function automatic logic beats(input arbiter_pkg::prio_t num_a,
                                   input int                 idx_a,
                                   input arbiter_pkg::prio_t num_b,
                                   input int                 idx_b);
        beats = (num_a < num_b) || ((num_a == num_b) && (idx_a < idx_b));
    endfunction

    function automatic arbiter_pkg::line_t onehot_index(input logic [NL-1:0] v);
        onehot_index = '0;
        for (int k = NL - 1; k >= 0; k--) begin
            if (v[k]) begin
                onehot_index = k[`ARB_LINE_W-1:0];
            end
        end
    endfunction

    logic [NL-1:0] line_win;

    for (genvar gi = 0; gi < NL; gi++) begin : g_line
        logic [NL-1:0] beaten_by;
        for (genvar gj = 0; gj < NL; gj++) begin : g_rival
            if (gj == gi) begin : g_self
                assign beaten_by[gj] = 1'b0;
            end else begin : g_other
                assign beaten_by[gj] = line_req[gj]
                                       && beats(line_num[gj], gj, line_num[gi], gi);
            end
        end
        assign line_win[gi] = line_req[gi] && ~|beaten_by;
    end

    wire                 any_win = |line_win;
    arbiter_pkg::line_t  win_idx;
    assign win_idx = onehot_index(line_win);

    // ****************************************************************
    // ownership state
    // ****************************************************************
    arbiter_pkg::arb_state_t state_q;
    arbiter_pkg::arb_state_t state_d;
    arbiter_pkg::line_t      owner_q;
    arbiter_pkg::line_t      owner_d;
    logic [NL-1:0]           gnt_q;
    logic [NL-1:0]           gnt_d;
    arbiter_pkg::prio_t      owner_num_q;

    wire owner_holds = line_req[owner_q];

    always_comb begin
        state_d = state_q;
        owner_d = owner_q;
        case (state_q)
            arbiter_pkg::ARB_IDLE: begin
                if (any_win) begin
                    state_d = arbiter_pkg::ARB_OWNED;
                    owner_d = win_idx;
                end
            end
            arbiter_pkg::ARB_OWNED: begin
                // a stronger newcomer cannot preempt; only release frees the bus
                if (!owner_holds) begin
                    if (any_win) begin
                        owner_d = win_idx;
                    end else begin
                        state_d = arbiter_pkg::ARB_IDLE;
                    end
                end
            end
            default: begin
                state_d = arbiter_pkg::ARB_IDLE;
            end
        endcase
    end

    // grants are decoded from a single owner index, never more than one bit
    assign gnt_d = (state_d == arbiter_pkg::ARB_OWNED)
                   ? (NL'(1) << owner_d) : '0;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_q     <= arbiter_pkg::ARB_IDLE;
            owner_q     <= '0;
            gnt_q       <= '0;
            owner_num_q <= '0;
        end else begin
            state_q     <= state_d;
            owner_q     <= owner_d;
            gnt_q       <= gnt_d;
            owner_num_q <= line_num[owner_d];
        end
    end

    // ****************************************************************
    // processor module local access
    // ****************************************************************
    processor_local_access u_proc_access (
        .mclk             (mclk),
        .rst_n            (rst_n),
        .io_processor_req (io_processor_req),
        .cpu_req          (cpu_req),
        .bus_gnt          (gnt_q[`ARB_LINE_PROC]),
        .proc_req         (proc_req),
        .io_processor_gnt (io_processor_gnt),
        .cpu_gnt          (cpu_gnt)
    );

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign mem_lower_gnt = {gnt_q[`ARB_LINE_MEM_LOWER_B], gnt_q[`ARB_LINE_MEM_LOWER_A]};
    assign mem_upper_gnt = {gnt_q[`ARB_LINE_MEM_UPPER_B], gnt_q[`ARB_LINE_MEM_UPPER_A]};
    assign selch_gnt     = gnt_q[`ARB_LINE_SELCH];
    assign bus_busy      = (state_q == arbiter_pkg::ARB_OWNED);
    assign bus_owner_num = owner_num_q;

endmodule

// ===== tb/arbiter_asserts.sv
// Purpose: port-level checks on the shared bus arbiter
// Assumes: normal jumpers; selector channel may be absent
// Notes:   jumpers are copied during reset, as the arbiter does
`timescale 1ns/100ps
`include "arbiter_consts.svh"
module arbiter_asserts (
    input wire logic                   mclk,
    input wire logic                   rst_n,
    input wire logic [`ARB_PRIO_W-1:0] mem_lower_jumper,
    input wire logic [`ARB_PRIO_W-1:0] proc_jumper,
    input wire logic [1:0]             mem_lower_req,
    input wire logic [1:0]             mem_upper_req,
    input wire logic                   selch_req,
    input wire logic                   io_processor_req,
    input wire logic                   cpu_req,
    input wire logic [1:0]             mem_lower_gnt,
    input wire logic [1:0]             mem_upper_gnt,
    input wire logic                   selch_gnt,
    input wire logic                   io_processor_gnt,
    input wire logic                   cpu_gnt,
    input wire logic                   bus_busy,
    input wire logic [`ARB_PRIO_W-1:0] bus_owner_num
);
    // ****************************************************************
    // checks
    // ****************************************************************
    logic [6:0]             req_all;
    logic [6:0]             gnt_all;
    logic [`ARB_PRIO_W-1:0] lower_num_q;
    logic [`ARB_PRIO_W-1:0] proc_num_q;
    assign req_all = {cpu_req, io_processor_req, selch_req, mem_upper_req, mem_lower_req};
    assign gnt_all = {cpu_gnt, io_processor_gnt, selch_gnt, mem_upper_gnt, mem_lower_gnt};
    // live jumpers may wander after reset, so keep what reset saw
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            lower_num_q <= mem_lower_jumper;
            proc_num_q  <= proc_jumper;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_single_owner: assert property ($onehot0(gnt_all) && bus_busy == (gnt_all != 7'h0))
        else $error("two owners or busy flag wrong");
    a_owner_keeps: assert property ((gnt_all & req_all) != 7'h0 |=> gnt_all == $past(gnt_all))
        else $error("owner lost the bus while requesting");
    a_release_drops: assert property ((gnt_all & ~req_all) != 7'h0 |=>
        (gnt_all & $past(gnt_all & ~req_all)) == 7'h0) else $error("grant kept after release");
    a_grant_has_req: assert property ((gnt_all & ~$past(req_all)) == 7'h0)
        else $error("grant without request");
    a_io_first: assert property ($rose(cpu_gnt) |-> !$past(io_processor_req))
        else $error("cpu beat io processor");
    a_cpu_weakest: assert property ($rose(cpu_gnt) |->
        $past({mem_upper_req, mem_lower_req}) == 4'h0) else $error("cpu beat memory");
    a_cpu_number: assert property ($rose(cpu_gnt) |-> bus_owner_num == proc_num_q)
        else $error("cpu owner number wrong");
    a_lower_second: assert property ($rose(mem_lower_gnt[1]) |->
        bus_owner_num == lower_num_q + 3'h1) else $error("lower memory second number wrong");
endmodule
bind shared_bus_priority_arbiter arbiter_asserts u_arbiter_asserts (.mclk, .rst_n,
    .mem_lower_jumper, .proc_jumper, .mem_lower_req, .mem_upper_req, .selch_req,
    .io_processor_req, .cpu_req, .mem_lower_gnt, .mem_upper_gnt, .selch_gnt,
    .io_processor_gnt, .cpu_gnt, .bus_busy, .bus_owner_num);

// ===== tb/bus_requester_model.sv
// Purpose: requesting modules on the far side of the arbiter
// Assumes: go bit starts a request on that line
// Notes:   each owner keeps the bus hold cycles, then lets go
`timescale 1ns/100ps
module bus_requester_model #(
    parameter int HOLD = 4
) (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic [6:0] go,
    input  wire logic [6:0] gnt,
    output logic      [6:0] req
);
    // ****************************************************************
    // requesters
    // ****************************************************************
    logic [3:0] held [7];
    always_ff @(posedge mclk) begin
        for (int i = 0; i < 7; i++) begin
            if (!rst_n) begin
                req[i]  <= 1'b0;
                held[i] <= 4'h0;
            end else if (go[i]) begin
                req[i] <= 1'b1;
            end else if (req[i] && gnt[i]) begin
                if (held[i] == 4'(HOLD - 1)) begin
                    req[i]  <= 1'b0;
                    held[i] <= 4'h0;
                end else begin
                    held[i] <= held[i] + 4'h1;
                end
            end
        end
    end
endmodule

// ===== tb/tb_top.sv
// Purpose: self-checking bench for the shared bus arbiter
// Assumes: line order lowA lowB upA upB selch io cpu
// Notes:   inputs change on the falling edge
`timescale 1ns/100ps
`include "arbiter_consts.svh"
module tb_top;
    // ****************************************************************
    // bench
    // ****************************************************************
    logic       mclk;
    logic       rst_n;
    logic [2:0] lo_jmp, up_jmp, sc_jmp, pr_jmp;
    logic       installed;
    logic [6:0] go;
    logic [6:0] req;
    wire  [6:0] gnt;
    wire        busy;
    wire  [2:0] owner;
    int         errors;
    int         total_checks;
    int         cycles;
    logic [2:0] exp_num [7] = '{`ARB_PRIO_MEM_LOWER, `ARB_PRIO_MEM_LOWER + `ARB_PRIO_STEP,
        `ARB_PRIO_MEM_UPPER, `ARB_PRIO_MEM_UPPER + `ARB_PRIO_STEP, `ARB_PRIO_SELCH,
        `ARB_PRIO_PROC, `ARB_PRIO_PROC};
    shared_bus_priority_arbiter u_shared_bus_priority_arbiter (.mclk, .rst_n,
        .mem_lower_jumper(lo_jmp), .mem_upper_jumper(up_jmp), .selch_jumper(sc_jmp),
        .proc_jumper(pr_jmp), .selch_installed(installed), .mem_lower_req(req[1:0]),
        .mem_upper_req(req[3:2]), .selch_req(req[4]), .io_processor_req(req[5]),
        .cpu_req(req[6]), .mem_lower_gnt(gnt[1:0]), .mem_upper_gnt(gnt[3:2]),
        .selch_gnt(gnt[4]), .io_processor_gnt(gnt[5]), .cpu_gnt(gnt[6]),
        .bus_busy(busy), .bus_owner_num(owner));
    bus_requester_model u_bus_requester_model (.mclk, .rst_n, .go, .gnt, .req);
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    task automatic check(input string name, input logic [6:0] seen, input logic [6:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic results();
        if (errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic do_reset(input logic inst);
        rst_n = 1'b0;
        installed = inst;
        lo_jmp = `ARB_PRIO_MEM_LOWER;
        up_jmp = `ARB_PRIO_MEM_UPPER;
        sc_jmp = `ARB_PRIO_SELCH;
        pr_jmp = `ARB_PRIO_PROC;
        // count rising edges: the clock's first step out of unknown reads as a falling edge
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        rst_n = 1'b1;
        // jumpers moved after reset must change nothing
        {lo_jmp, up_jmp, sc_jmp, pr_jmp, installed} = {12'h000, ~inst};
    endtask
    task automatic pulse(input logic [6:0] lines);
        go = lines;
        @(negedge mclk);
        go = 7'h0;
    endtask
    task automatic wait_gnt(input int idx);
        int n;
        n = 0;
        while (gnt[idx] !== 1'b1 && n < 40) begin
            @(negedge mclk);
            n++;
        end
        check("grant", gnt, 7'h1 << idx);
        check("owner", 7'(owner), 7'(exp_num[idx]));
        check("busy", 7'(busy), 7'h1);
    endtask
    task automatic s_priority();
        pulse(7'h7f);
        for (int i = 0; i < 7; i++) wait_gnt(i);
        repeat (6) @(negedge mclk);
        check("idle", 7'(busy), 7'h0);
    endtask
    task automatic s_no_preempt();
        pulse(7'h40);
        wait_gnt(6);
        pulse(7'h21);
        // one more edge so the arbiter has really sampled the stronger request
        @(negedge mclk);
        check("held off", gnt, 7'h40);
        wait_gnt(0);
        wait_gnt(5);
        repeat (6) @(negedge mclk);
    endtask
    task automatic s_selch_absent();
        do_reset(1'b0);
        pulse(7'h50);
        wait_gnt(6);
        repeat (6) @(negedge mclk);
        check("selch ignored", gnt, 7'h0);
    endtask
    initial begin
        go = 7'h0;
        errors = 0;
        total_checks = 0;
        do_reset(1'b1);
        s_priority();
        s_no_preempt();
        s_selch_absent();
        results();
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 2000) begin
            errors++;
            results();
        end
    end
endmodule
